//--- design/pxb_port_io_crossbar.sv
/*
  Port pin configuration and crossbar for two 8-pin ports: per-pin input
  and output modes, skip bits, peripheral routing, weak pullups and the
  register file on the special-function-register bus.
  Assumes peripherals present drive requests per function slot, pads resolve
  pin_out/pin_oe_n/pin_pullup externally, and the bus is single cycle.
*/
`timescale 1ns/100ps
module pxb_port_io_crossbar #(
  parameter int NPIN = pxb_pkg::NUM_PINS,
  parameter int NFUNC = pxb_pkg::NUM_FUNCS
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  input wire logic [7:0] sfr_wdata, // Write data
  output logic [7:0] sfr_rdata, // Read data, valid cycle after strobe
  input wire logic [1:0] slave_select_mode, // SPI slave-select mode field
  input wire logic [NFUNC-1:0] periph_out, // Peripheral output levels
  input wire logic [NFUNC-1:0] periph_drive, // Peripheral wants to drive
  output logic [NFUNC-1:0] periph_in, // Pin levels back to peripherals
  input wire logic [NPIN-1:0] pin_in, // Pad input levels
  output logic [NPIN-1:0] pin_out, // Pad output levels
  output logic [NPIN-1:0] pin_oe_n, // Pad driver enable, low drives
  output logic [NPIN-1:0] pin_pullup, // Weak pullup enable
  output logic [NPIN-1:0] pin_rx_en // Digital receiver enable
);

  localparam int PW = $clog2(NPIN);
  localparam int FW = $clog2(NFUNC);

  logic [NPIN-1:0] port_latch;
  logic [NPIN-1:0] pin_input_mode;
  logic [NPIN-1:0] pin_output_mode;
  logic [NPIN-1:0] pin_skip;
  logic [7:0] peripheral_route_0;
  logic [7:0] peripheral_route_1;
  logic [NPIN-1:0] next_port_latch;
  logic [NPIN-1:0] next_pin_input_mode;
  logic [NPIN-1:0] next_pin_output_mode;
  logic [NPIN-1:0] next_pin_skip;
  logic [7:0] next_peripheral_route_0;
  logic [7:0] next_peripheral_route_1;
  logic [7:0] next_sfr_rdata;
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] next_pin_oe_n;
  logic [NPIN-1:0] next_pin_pullup;
  logic [NPIN-1:0] next_pin_rx_en;
  logic [NFUNC-1:0] next_periph_in;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_level;
  logic [NFUNC-1:0] func_req;
  logic [NPIN-1:0] pin_taken;
  logic [NPIN-1:0][FW-1:0] pin_func;
  logic [NFUNC-1:0] func_ok;
  logic [NFUNC-1:0][PW-1:0] func_pin;
  logic crossbar_on;
  logic weak_pullup_disable;
  logic four_wire;

  assign crossbar_on = peripheral_route_1[pxb_pkg::R1_XBAR_ON];
  assign weak_pullup_disable = peripheral_route_1[pxb_pkg::R1_WEAK_PULLUP_DISABLE];
  // Any non-zero mode uses the slave-select line
  assign four_wire = (slave_select_mode != 2'h0);

  // Pad inputs come from outside the clock domain
  pxb_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d(pin_in),
    .q(pin_sync)
  );

  // Analog pins have no receiver, so they read back as zero
  assign pin_level = pin_sync & pin_input_mode;

  // Function requests from the route bits
  always_comb
  begin
    func_req = '0;
    func_req[pxb_pkg::FN_UART_TX] = peripheral_route_0[pxb_pkg::R0_UART];
    func_req[pxb_pkg::FN_UART_RX] = peripheral_route_0[pxb_pkg::R0_UART];
    func_req[pxb_pkg::FN_SPI_SCK] = peripheral_route_0[pxb_pkg::R0_SPI];
    func_req[pxb_pkg::FN_SPI_MISO] = peripheral_route_0[pxb_pkg::R0_SPI];
    func_req[pxb_pkg::FN_SPI_MOSI] = peripheral_route_0[pxb_pkg::R0_SPI];
    func_req[pxb_pkg::FN_SPI_SS] = peripheral_route_0[pxb_pkg::R0_SPI] & four_wire;
    func_req[pxb_pkg::FN_LIN_TX] = peripheral_route_0[pxb_pkg::R0_LIN];
    func_req[pxb_pkg::FN_LIN_RX] = peripheral_route_0[pxb_pkg::R0_LIN];
    func_req[pxb_pkg::FN_SYSCLK] = peripheral_route_0[pxb_pkg::R0_SYSCLK];
    func_req[pxb_pkg::FN_CMP_SYNC] = peripheral_route_0[pxb_pkg::R0_CMP_SYNC];
    func_req[pxb_pkg::FN_CMP_ASYNC] = peripheral_route_0[pxb_pkg::R0_CMP_ASYNC];
  end

  // Skipped pins are withheld from the allocator
  pxb_alloc #(
    .NPIN(NPIN),
    .NFUNC(NFUNC),
    .PW(PW),
    .FW(FW)
  ) u_alloc (
    .func_req(func_req),
    .pin_free(~pin_skip),
    .pin_taken(pin_taken),
    .pin_func(pin_func),
    .func_ok(func_ok),
    .func_pin(func_pin)
  );

  // Register writes; mode bits change only by software write, never by routing
  always_comb
  begin
    next_port_latch = port_latch;
    next_pin_input_mode = pin_input_mode;
    next_pin_output_mode = pin_output_mode;
    next_pin_skip = pin_skip;
    next_peripheral_route_0 = peripheral_route_0;
    next_peripheral_route_1 = peripheral_route_1;
    if (sfr_wr)
    begin
      case (sfr_addr)
        pxb_pkg::ADDR_PORT0: next_port_latch[7:0] = sfr_wdata;
        pxb_pkg::ADDR_PORT1: next_port_latch[15:8] = sfr_wdata;
        pxb_pkg::ADDR_IN_MODE0: next_pin_input_mode[7:0] = sfr_wdata;
        pxb_pkg::ADDR_IN_MODE1: next_pin_input_mode[15:8] = sfr_wdata;
        pxb_pkg::ADDR_OUT_MODE0: next_pin_output_mode[7:0] = sfr_wdata;
        pxb_pkg::ADDR_OUT_MODE1: next_pin_output_mode[15:8] = sfr_wdata;
        pxb_pkg::ADDR_SKIP0: next_pin_skip[7:0] = sfr_wdata;
        pxb_pkg::ADDR_SKIP1: next_pin_skip[15:8] = sfr_wdata;
        pxb_pkg::ADDR_ROUTE0: next_peripheral_route_0 = sfr_wdata & pxb_pkg::ROUTE0_MASK;
        pxb_pkg::ADDR_ROUTE1: next_peripheral_route_1 = sfr_wdata & pxb_pkg::ROUTE1_MASK;
        default: ;
      endcase
    end
  end

  // Read data; port addresses return pin levels, not the latch
  always_comb
  begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd)
    begin
      case (sfr_addr)
        pxb_pkg::ADDR_PORT0: next_sfr_rdata = pin_level[7:0];
        pxb_pkg::ADDR_PORT1: next_sfr_rdata = pin_level[15:8];
        pxb_pkg::ADDR_IN_MODE0: next_sfr_rdata = pin_input_mode[7:0];
        pxb_pkg::ADDR_IN_MODE1: next_sfr_rdata = pin_input_mode[15:8];
        pxb_pkg::ADDR_OUT_MODE0: next_sfr_rdata = pin_output_mode[7:0];
        pxb_pkg::ADDR_OUT_MODE1: next_sfr_rdata = pin_output_mode[15:8];
        pxb_pkg::ADDR_SKIP0: next_sfr_rdata = pin_skip[7:0];
        pxb_pkg::ADDR_SKIP1: next_sfr_rdata = pin_skip[15:8];
        pxb_pkg::ADDR_ROUTE0: next_sfr_rdata = peripheral_route_0;
        pxb_pkg::ADDR_ROUTE1: next_sfr_rdata = peripheral_route_1;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  // Pad control per pin; registered, so pads follow the registers one cycle late
  always_comb
  begin
    logic taken;
    logic want;
    logic val;
    logic drive;
    taken = 1'b0;
    want = 1'b0;
    val = 1'b0;
    drive = 1'b0;
    next_pin_out = '0;
    next_pin_oe_n = '1;
    next_pin_pullup = '0;
    next_pin_rx_en = '0;
    for (int p = 0; p < NPIN; p++)
    begin
      taken = crossbar_on & pin_taken[p];
      want = taken ? periph_drive[pin_func[p]] : crossbar_on;
      val = taken ? periph_out[pin_func[p]] : port_latch[p];
      // Open-drain only ever pulls low; a one is left to the pullup
      drive = pin_input_mode[p] & want & (pin_output_mode[p] | !val);
      next_pin_oe_n[p] = !drive;
      next_pin_out[p] = drive & val;
      next_pin_pullup[p] = pin_input_mode[p] & !pin_output_mode[p] & !weak_pullup_disable & !drive;
      next_pin_rx_en[p] = pin_input_mode[p];
    end
  end

  // Unrouted functions see an idle-high level
  always_comb
  begin
    next_periph_in = '1;
    for (int f = 0; f < NFUNC; f++)
    begin
      if (crossbar_on && func_ok[f])
      begin
        next_periph_in[f] = pin_level[func_pin[f]];
      end
    end
  end

  // State and output registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      port_latch <= {2{pxb_pkg::RST_PORT_LATCH}};
      pin_input_mode <= {2{pxb_pkg::RST_IN_MODE}};
      pin_output_mode <= {2{pxb_pkg::RST_OUT_MODE}};
      pin_skip <= {2{pxb_pkg::RST_SKIP}};
      peripheral_route_0 <= pxb_pkg::RST_ROUTE0;
      peripheral_route_1 <= pxb_pkg::RST_ROUTE1;
      sfr_rdata <= pxb_pkg::RST_RDATA;
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_pullup <= '1;
      pin_rx_en <= '1;
      periph_in <= '1;
    end
    else
    begin
      port_latch <= next_port_latch;
      pin_input_mode <= next_pin_input_mode;
      pin_output_mode <= next_pin_output_mode;
      pin_skip <= next_pin_skip;
      peripheral_route_0 <= next_peripheral_route_0;
      peripheral_route_1 <= next_peripheral_route_1;
      sfr_rdata <= next_sfr_rdata;
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      pin_pullup <= next_pin_pullup;
      pin_rx_en <= next_pin_rx_en;
      periph_in <= next_periph_in;
    end
  end

  // Checks on pads against the configuration one cycle earlier, on register reads and on routing
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_rx_follows_mode;
    ##1 pin_rx_en == $past(pin_input_mode);
  endproperty
  a_rx_follows_mode: assert property (p_rx_follows_mode)
    else $error("receiver enable differs from input mode");

  property p_analog_quiet;
    ##1 ((~$past(pin_input_mode)) & ((~pin_oe_n) | pin_pullup | pin_rx_en)) == '0;
  endproperty
  a_analog_quiet: assert property (p_analog_quiet)
    else $error("analog pin has driver, pullup or receiver");

  property p_reset_digital;
    $fell(srst) |-> pin_input_mode == '1 && pin_rx_en == '1;
  endproperty
  a_reset_digital: assert property (p_reset_digital)
    else $error("pins not digital after reset");

  property p_pushpull_high;
    (crossbar_on && pin_input_mode[0] && pin_output_mode[0] && !pin_taken[0] && port_latch[0])
      |=> !pin_oe_n[0] && pin_out[0];
  endproperty
  a_pushpull_high: assert property (p_pushpull_high)
    else $error("push-pull pin not driving high");

  property p_opendrain_pullup;
    (!weak_pullup_disable && pin_input_mode[1] && !pin_output_mode[1] && (!crossbar_on || port_latch[1])
      && !pin_taken[1]) |=> pin_pullup[1] && pin_oe_n[1];
  endproperty
  a_opendrain_pullup: assert property (p_opendrain_pullup)
    else $error("open-drain pin lacks pullup");

  property p_no_pullup_pushpull_low;
    ##1 ((pin_pullup & $past(pin_output_mode)) | (pin_pullup & ~pin_oe_n & ~pin_out)) == '0;
  endproperty
  a_no_pullup_pushpull_low: assert property (p_no_pullup_pushpull_low)
    else $error("pullup on push-pull or low pin");

  property p_off_no_drive;
    !crossbar_on |=> pin_oe_n == '1;
  endproperty
  a_off_no_drive: assert property (p_off_no_drive)
    else $error("driver on while crossbar disabled");

  property p_off_periph_idle;
    !crossbar_on |=> periph_in == '1;
  endproperty
  a_off_periph_idle: assert property (p_off_periph_idle)
    else $error("peripheral input routed while disabled");

  // A skipped push-pull pin must behave as a plain port output at the pad
  property p_skip_untouched;
    (crossbar_on && pin_skip[0] && pin_input_mode[0] && pin_output_mode[0])
      |=> !pin_oe_n[0] && pin_out[0] == $past(port_latch[0]);
  endproperty
  a_skip_untouched: assert property (p_skip_untouched)
    else $error("skipped pin not driven from port latch");

  property p_reserved_zero;
    (sfr_rd && sfr_addr == pxb_pkg::ADDR_ROUTE0) |=> sfr_rdata[7:6] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved route bits read non-zero");

  property p_route_gate;
    (func_ok & ~func_req) == '0;
  endproperty
  a_route_gate: assert property (p_route_gate)
    else $error("function routed without its enable");

  property p_ss_four_wire;
    func_ok[pxb_pkg::FN_SPI_SS] |-> four_wire && peripheral_route_0[pxb_pkg::R0_SPI];
  endproperty
  a_ss_four_wire: assert property (p_ss_four_wire)
    else $error("slave select routed in three-wire mode");

  property p_uart_first;
    (peripheral_route_0[pxb_pkg::R0_UART] && pin_skip[1:0] == 2'h0) |-> func_ok[pxb_pkg::FN_UART_TX]
      && func_pin[pxb_pkg::FN_UART_TX] == PW'(0) && func_pin[pxb_pkg::FN_UART_RX] == PW'(1);
  endproperty
  a_uart_first: assert property (p_uart_first)
    else $error("UART not placed on lowest free pins");

endmodule : pxb_port_io_crossbar

//--- design/pxb_pkg.sv
/*
  Constants for the port pin configuration and crossbar block: register
  addresses, field positions, reset values and crossbar function slots.
  Assumes an 8-bit special-function-register bus that uses these addresses.
*/
// Operation
// - Input mode one digital, zero analog.
// - Analog pin: no pullup, driver or receiver.
// - Reset leaves every pin digital input.
// - Output mode bit picks open-drain or push-pull.
// - Pullup disable zero enables open-drain pullups.
// - No pullup on push-pull, low-driven, analog pins.
// - Crossbar inactive until enable bit set.
// - Output drivers off while crossbar disabled.
// - Crossbar passes over skipped pins.
// - Route bits five..zero enable six functions.
// - Slave select routed only in four-wire mode.
package pxb_pkg;

  // Pin and function counts
  localparam int NUM_PINS = 16;
  localparam int NUM_FUNCS = 11;

  // Register addresses
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_OUT_MODE0 = 8'hA4;
  localparam logic [7:0] ADDR_OUT_MODE1 = 8'hA5;
  localparam logic [7:0] ADDR_SKIP0 = 8'hD4;
  localparam logic [7:0] ADDR_SKIP1 = 8'hD5;
  localparam logic [7:0] ADDR_ROUTE0 = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE1 = 8'hE2;
  localparam logic [7:0] ADDR_IN_MODE0 = 8'hF1;
  localparam logic [7:0] ADDR_IN_MODE1 = 8'hF2;

  // Reset values
  localparam logic [7:0] RST_PORT_LATCH = 8'hFF;
  localparam logic [7:0] RST_IN_MODE = 8'hFF;
  localparam logic [7:0] RST_OUT_MODE = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_ROUTE0 = 8'h00;
  localparam logic [7:0] RST_ROUTE1 = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // First route register fields; bits seven and six are reserved
  localparam int R0_UART = 0;
  localparam int R0_SPI = 1;
  localparam int R0_LIN = 2;
  localparam int R0_SYSCLK = 3;
  localparam int R0_CMP_SYNC = 4;
  localparam int R0_CMP_ASYNC = 5;
  localparam logic [7:0] ROUTE0_MASK = 8'h3F;

  // Second route register fields
  localparam int R1_XBAR_ON = 6;
  localparam int R1_WEAK_PULLUP_DISABLE = 7;
  localparam logic [7:0] ROUTE1_MASK = 8'hC0;

  // Crossbar function slots in priority order
  localparam int FN_UART_TX = 0;
  localparam int FN_UART_RX = 1;
  localparam int FN_SPI_SCK = 2;
  localparam int FN_SPI_MISO = 3;
  localparam int FN_SPI_MOSI = 4;
  localparam int FN_SPI_SS = 5;
  localparam int FN_LIN_TX = 6;
  localparam int FN_LIN_RX = 7;
  localparam int FN_SYSCLK = 8;
  localparam int FN_CMP_SYNC = 9;
  localparam int FN_CMP_ASYNC = 10;

endpackage : pxb_pkg

//--- design/pxb_sync.sv
/*
  Three-stage input synchroniser with agreement filter for port pins.
  Assumes inputs are asynchronous to clk; output is in the clk domain.
*/
`timescale 1ns/100ps
module pxb_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] d, // Raw pin levels
  output logic [WIDTH-1:0] q // Filtered levels
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_q;

  // A change is taken only once stages two and three agree; stage one feeds stage two alone
  always_comb
  begin
    next_q = (s2 & s3) | (q & (s2 ^ s3));
  end

  // Idle-high reset matches a pulled-up pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q <= '1;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

endmodule : pxb_sync

//--- design/pxb_alloc.sv
/*
  Crossbar allocator: places requested functions onto free pins in
  slot order, each on the lowest free pin left. Purely combinational.
  Assumes slot zero carries the highest priority.
*/
`timescale 1ns/100ps
module pxb_alloc #(
  parameter int NPIN = 16,
  parameter int NFUNC = 11,
  parameter int PW = $clog2(NPIN),
  parameter int FW = $clog2(NFUNC)
) (
  input wire logic [NFUNC-1:0] func_req, // Functions enabled for routing
  input wire logic [NPIN-1:0] pin_free, // Pins not skipped
  output logic [NPIN-1:0] pin_taken, // Pin carries a function
  output logic [NPIN-1:0][FW-1:0] pin_func, // Function slot on each pin
  output logic [NFUNC-1:0] func_ok, // Function found a pin
  output logic [NFUNC-1:0][PW-1:0] func_pin // Pin of each function
);

  // Greedy walk; a request left without a free pin simply stays unrouted
  always_comb
  begin
    logic [NPIN-1:0] avail;
    logic found;
    avail = pin_free;
    found = 1'b0;
    pin_taken = '0;
    pin_func = '0;
    func_ok = '0;
    func_pin = '0;
    for (int f = 0; f < NFUNC; f++)
    begin
      found = 1'b0;
      for (int p = 0; p < NPIN; p++)
      begin
        if (func_req[f] && avail[p] && !found)
        begin
          found = 1'b1;
          avail[p] = 1'b0;
          pin_taken[p] = 1'b1;
          pin_func[p] = FW'(f);
          func_ok[f] = 1'b1;
          func_pin[f] = PW'(p);
        end
      end
    end
  end

endmodule : pxb_alloc

//--- testbench/pxb_pad_model.sv
/*
  Pad model for the port pins: resolves each pin from the block's driver,
  its weak pullup and a level from off chip.
  Assumes the off-chip source is weaker than both driver and pullup.
*/
`timescale 1ns/100ps
module pxb_pad_model #(
  parameter int NPIN = 16
) (
  input wire logic [NPIN-1:0] pin_out, // Block output level
  input wire logic [NPIN-1:0] pin_oe_n, // Block driver enable, low drives
  input wire logic [NPIN-1:0] pin_pullup, // Weak pullup enable
  input wire logic [NPIN-1:0] ext_level, // Off-chip level, changed by the bench
  output logic [NPIN-1:0] pad // Resolved pin level
);
  // Driver wins, then pullup; a released pin never keeps an old value
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      if (!pin_oe_n[i])
        pad[i] = pin_out[i];
      else if (pin_pullup[i])
        pad[i] = 1'b1;
      else
        pad[i] = ext_level[i];
    end
  end
endmodule : pxb_pad_model

//--- testbench/test_port_io_crossbar.sv
/*
  Self-checking bench for the port pin configuration and crossbar block.
  Assumes the pad model closes the loop from pin outputs back to pin_in.
*/
`timescale 1ns/100ps
module test_port_io_crossbar;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [1:0] ssm = 2'h0;
  logic [10:0] p_out = 11'h000;
  logic [10:0] p_drv = 11'h000;
  logic [10:0] p_in, e_pin;
  logic [15:0] pad, pin_out, pin_oe_n, pin_pullup, pin_rx_en;
  logic [15:0] ext = 16'h0000;
  // Reference model state
  logic [15:0] inm, outm, skp, lat, e_oe, e_out, e_pu, e_pad;
  logic [7:0] r0, rv;
  logic wpd;
  logic [7:0] raddr [11] = '{8'h80, 8'h90, 8'hA4, 8'hA5, 8'hD4, 8'hD5, 8'hE1, 8'hE2, 8'hF1, 8'hF2, 8'h81};
  logic [7:0] rexp [11] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  int owner [16];
  int fpin [11];
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 89;

  always #10 clk = ~clk;

  pxb_port_io_crossbar dut (
    .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .slave_select_mode(ssm), .periph_out(p_out),
    .periph_drive(p_drv), .periph_in(p_in), .pin_in(pad), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .pin_rx_en(pin_rx_en)
  );

  pxb_pad_model pads (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_level(ext), .pad(pad)
  );

  // Ceiling sits far above the expected run of about 2900 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One idle edge between strobes, so no signal is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic wr2(input logic [7:0] a0, input logic [7:0] a1, input logic [15:0] v);
    wr(a0, v[7:0]);
    wr(a1, v[15:8]);
  endtask : wr2

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    v = sfr_rdata;
  endtask : rd

  // Expected pads with the crossbar on, from the current configuration
  task automatic predict();
    logic [10:0] req;
    logic v, d;
    req = {r0[5], r0[4], r0[3], r0[2], r0[2], r0[1] & (ssm != 2'h0), {3{r0[1]}}, r0[0], r0[0]};
    for (int p = 0; p < 16; p++)
      owner[p] = -1;
    // Slots in priority order, each on the lowest free unskipped pin
    for (int f = 0; f < 11; f++)
    begin
      fpin[f] = -1;
      for (int p = 0; p < 16; p++)
        if (req[f] && fpin[f] < 0 && !skp[p] && owner[p] < 0)
        begin
          owner[p] = f;
          fpin[f] = p;
        end
    end
    for (int p = 0; p < 16; p++)
    begin
      v = (owner[p] >= 0) ? p_out[owner[p]] : lat[p];
      d = inm[p] & ((owner[p] >= 0) ? p_drv[owner[p]] : 1'b1) & (outm[p] | !v);
      e_oe[p] = !d;
      e_out[p] = d & v;
      e_pu[p] = inm[p] & !outm[p] & !wpd & !d;
      e_pad[p] = d ? v : (e_pu[p] | ext[p]);
    end
    for (int f = 0; f < 11; f++)
      e_pin[f] = (fpin[f] >= 0) ? e_pad[fpin[f]] : 1'b1;
  endtask : predict

  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(pin_oe_n, 16'hFFFF, "reset oe_n");
    chk(pin_out, 16'h0000, "reset out");
    chk(pin_pullup, 16'hFFFF, "reset pullup");
    chk(pin_rx_en, 16'hFFFF, "reset rx");
    chk({5'h00, p_in}, 16'h07FF, "reset periph_in");
    // Reset value of every register, plus one unmapped address
    foreach (raddr[i])
    begin
      rd(raddr[i], rv);
      chk({8'h00, rv}, {8'h00, rexp[i]}, "reset register");
    end
    wr(pxb_pkg::ADDR_ROUTE0, 8'hFF);
    rd(pxb_pkg::ADDR_ROUTE0, rv);
    chk({8'h00, rv}, 16'h003F, "reserved bits");
    wr(8'h81, 8'h5A);
    rd(8'h81, rv);
    chk({8'h00, rv}, 16'h0000, "unmapped");
    $display("test reset_and_registers done");
    for (int it = 0; it < 60; it++)
    begin
      wr(pxb_pkg::ADDR_ROUTE1, 8'h00);
      inm = 16'($random(seed));
      outm = 16'($random(seed));
      skp = 16'($random(seed)) | ~inm;
      lat = 16'($random(seed));
      r0 = 8'($random(seed)) & 8'h3F;
      wpd = 1'($random(seed));
      // Input modes, output modes, skips, port latches, routes, then enable last
      wr2(pxb_pkg::ADDR_IN_MODE0, pxb_pkg::ADDR_IN_MODE1, inm);
      wr2(pxb_pkg::ADDR_OUT_MODE0, pxb_pkg::ADDR_OUT_MODE1, outm);
      wr2(pxb_pkg::ADDR_SKIP0, pxb_pkg::ADDR_SKIP1, skp);
      wr2(pxb_pkg::ADDR_PORT0, pxb_pkg::ADDR_PORT1, lat);
      wr(pxb_pkg::ADDR_ROUTE0, r0);
      @(posedge clk);
      ssm <= 2'($random(seed));
      p_out <= 11'($random(seed));
      p_drv <= 11'($random(seed));
      ext <= 16'($random(seed));
      repeat (8) @(posedge clk);
      #1;
      chk(pin_oe_n, 16'hFFFF, "crossbar off drivers");
      chk({5'h00, p_in}, 16'h07FF, "crossbar off periph_in");
      wr(pxb_pkg::ADDR_ROUTE1, {wpd, 1'b1, 6'h00});
      repeat (8) @(posedge clk);
      #1;
      predict();
      chk(pin_oe_n, e_oe, "oe_n");
      chk(pin_out, e_out, "out");
      chk(pin_pullup, e_pu, "pullup");
      chk(pin_rx_en, inm, "rx");
      chk({5'h00, p_in}, {5'h00, e_pin}, "periph_in");
      rd(pxb_pkg::ADDR_PORT0, rv);
      chk({8'h00, rv}, {8'h00, e_pad[7:0] & inm[7:0]}, "port0 read");
      rd(pxb_pkg::ADDR_PORT1, rv);
      chk({8'h00, rv}, {8'h00, e_pad[15:8] & inm[15:8]}, "port1 read");
      rd(pxb_pkg::ADDR_ROUTE0, rv);
      chk({8'h00, rv}, {8'h00, r0}, "route0 read");
      rd(pxb_pkg::ADDR_OUT_MODE1, rv);
      chk({8'h00, rv}, {8'h00, outm[15:8]}, "out mode kept");
    end
    $display("test random_routing done");
    // Reset in mid-run must bring back digital inputs and quiet pads
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(pin_rx_en, 16'hFFFF, "mid reset rx");
    chk(pin_oe_n, 16'hFFFF, "mid reset oe_n");
    chk({5'h00, p_in}, 16'h07FF, "mid reset periph_in");
    rd(pxb_pkg::ADDR_IN_MODE0, rv);
    chk({8'h00, rv}, 16'h00FF, "mid reset in mode 0");
    rd(pxb_pkg::ADDR_IN_MODE1, rv);
    chk({8'h00, rv}, 16'h00FF, "mid reset in mode 1");
    rd(pxb_pkg::ADDR_ROUTE1, rv);
    chk({8'h00, rv}, 16'h0000, "mid reset route1");
    $display("test mid_run_reset done");
    give_verdict();
  end
endmodule : test_port_io_crossbar
